// file: rtl/isee_pkg.sv
// Shared constants and types of the serial memory slave
package isee_pkg;

    // ****************************************
    // Byte framing
    // ****************************************
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] TENTH_SLOT = 4'h1;
    localparam int BYTE_BITS = 8;
    localparam int RW_POS = 0;
    localparam int CE_LSB = 1;
    localparam int CE_MSB = 3;
    localparam int TYPE_LSB = 4;
    localparam int TYPE_MSB = 7;
    localparam int CE_BITS = 3;

    // ****************************************
    // Array geometry
    // ****************************************
    localparam int PAGE_BITS = 4;
    localparam int PAGE_BYTES = 16;
    localparam int BITS_PER_KBIT_BYTES = 128;
    localparam int DEF_KBITS = 16;
    localparam int WIDE_ADDR = 11;
    localparam int DEF_WRITE_CYCLES = 1000;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SEL,
        ST_ADDR,
        ST_WDATA,
        ST_RDATA,
        ST_BUSY
    } isee_state_type;

    typedef struct packed {
        logic scl;
        logic sda;
        logic wp;
        logic [2:0] ce;
    } isee_pins_type;

    // Lines idle high, so reset them high to avoid a false start
    localparam isee_pins_type PINS_RESET = '{scl: 1'b1, sda: 1'b1, wp: 1'b0, ce: 3'h0};

endpackage

// file: rtl/isee_slave.sv
// Two-wire serial slave with byte-addressed nonvolatile array
`timescale 1ns/1ps

module isee_slave
    import isee_pkg::*;
#(
    parameter int KBITS = DEF_KBITS,
    parameter int WRITE_CYCLES = DEF_WRITE_CYCLES,
    // Arbitrary value, set to the real type code when integrating
    parameter logic [3:0] DEVICE_TYPE_ID = 4'h5
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic sclClk,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic [2:0] chipSelPin,
    input wire logic writeProtectIn,
    output logic writeBusy
);

    localparam int AW = $clog2(KBITS * BITS_PER_KBIT_BYTES);
    localparam int MEM_BYTES = 2 ** AW;
    localparam int HI_BITS = (AW > BYTE_BITS) ? AW - BYTE_BITS : 0;
    localparam int CNT_W = $clog2(WRITE_CYCLES + 1);

    // ****************************************
    // Helpers
    // ****************************************
    // Enable positions taken over by high address bits are not compared
    function automatic logic ceMatch(input logic [2:0] selCe, input logic [2:0] pins);
        logic ok;
        ok = 1'b1;
        for (int j = 0; j < CE_BITS; j++) begin
            if (j >= HI_BITS && selCe[j] != pins[j]) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    function automatic logic [AW-1:0] withHi(input logic [AW-1:0] a, input logic [2:0] selCe);
        logic [WIDE_ADDR-1:0] w;
        w = WIDE_ADDR'(a);
        for (int j = 0; j < HI_BITS; j++) begin
            w[BYTE_BITS + j] = selCe[j];
        end
        return w[AW-1:0];
    endfunction

    function automatic logic [AW-1:0] withLow(input logic [AW-1:0] a, input logic [7:0] b);
        logic [WIDE_ADDR-1:0] w;
        w = WIDE_ADDR'(a);
        w[BYTE_BITS-1:0] = b;
        return w[AW-1:0];
    endfunction

    // ****************************************
    // Link clock domain
    // ****************************************
    logic linkRst1_ff;
    logic linkRst2_ff;
    logic riseBit_ff;
    logic riseTgl_ff;

    always_ff @(posedge sclClk) begin
        linkRst1_ff <= reset;
        linkRst2_ff <= linkRst1_ff;
    end

    // Bit is held a whole clock period, long enough for the toggle to cross
    always_ff @(posedge sclClk) begin
        if (linkRst2_ff) begin
            riseBit_ff <= 1'b0;
            riseTgl_ff <= 1'b0;
        end else begin
            riseBit_ff <= sdaIn;
            riseTgl_ff <= ~riseTgl_ff;
        end
    end

    // ****************************************
    // Synchronisers and bus events
    // ****************************************
    isee_pins_type pins1_ff;
    isee_pins_type pins2_ff;
    logic prevScl_ff;
    logic prevSda_ff;
    logic tgl1_ff;
    logic tgl2_ff;
    logic tglSeen_ff;

    always_ff @(posedge clk) begin
        if (reset) begin
            pins1_ff <= PINS_RESET;
            pins2_ff <= PINS_RESET;
            prevScl_ff <= 1'b1;
            prevSda_ff <= 1'b1;
        end else begin
            pins1_ff <= '{scl: sclIn, sda: sdaIn, wp: writeProtectIn, ce: chipSelPin};
            pins2_ff <= pins1_ff;
            prevScl_ff <= pins2_ff.scl;
            prevSda_ff <= pins2_ff.sda;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            tgl1_ff <= 1'b0;
            tgl2_ff <= 1'b0;
            tglSeen_ff <= 1'b0;
        end else begin
            tgl1_ff <= riseTgl_ff;
            tgl2_ff <= tgl1_ff;
            tglSeen_ff <= tgl2_ff;
        end
    end

    logic startEv;
    logic stopEv;
    logic fallEv;
    logic riseEv;

    assign startEv = prevScl_ff & pins2_ff.scl & prevSda_ff & ~pins2_ff.sda;
    assign stopEv = prevScl_ff & pins2_ff.scl & ~prevSda_ff & pins2_ff.sda;
    assign fallEv = prevScl_ff & ~pins2_ff.scl;
    assign riseEv = tgl2_ff ^ tglSeen_ff;

    // ****************************************
    // Protocol engine
    // ****************************************
    isee_state_type state_ff;
    logic [3:0] bitCnt_ff;
    logic [7:0] shift_ff;
    logic sdaOe_ff;
    logic [AW-1:0] addr_ff;
    logic wpSeen_ff;
    logic ackDone_ff;
    logic dataSeen_ff;
    logic [CNT_W-1:0] busyCnt_ff;
    logic [7:0] mem [MEM_BYTES];
    logic [7:0] pageData_ff [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] pageValid_ff;

    logic byteDone;
    logic writeGo;
    logic pageStore;
    logic commit;
    logic selMatch;

    assign byteDone = fallEv && bitCnt_ff == ACK_SLOT;
    assign selMatch = shift_ff[TYPE_MSB:TYPE_LSB] == DEVICE_TYPE_ID
        && ceMatch(shift_ff[CE_MSB:CE_LSB], pins2_ff.ce);
    assign writeGo = state_ff == ST_WDATA && bitCnt_ff == TENTH_SLOT && dataSeen_ff;
    assign pageStore = byteDone && state_ff == ST_WDATA && !wpSeen_ff;
    assign commit = state_ff == ST_BUSY && busyCnt_ff == '0;

    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= ST_IDLE;
            bitCnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            sdaOe_ff <= 1'b0;
            addr_ff <= '0;
            wpSeen_ff <= 1'b0;
            ackDone_ff <= 1'b0;
            dataSeen_ff <= 1'b0;
        end else if (state_ff == ST_BUSY) begin
            // Deaf to the bus, so polling selects get no ack
            sdaOe_ff <= 1'b0;
            if (commit) begin
                state_ff <= ST_IDLE;
            end
        end else if (stopEv) begin
            sdaOe_ff <= 1'b0;
            ackDone_ff <= 1'b0;
            state_ff <= writeGo ? ST_BUSY : ST_IDLE;
        end else if (startEv) begin
            state_ff <= ST_SEL;
            bitCnt_ff <= 4'h0;
            sdaOe_ff <= 1'b0;
            ackDone_ff <= 1'b0;
            dataSeen_ff <= 1'b0;
            wpSeen_ff <= pins2_ff.wp;
        end else if (state_ff != ST_IDLE) begin
            if ((state_ff == ST_SEL || state_ff == ST_ADDR) && pins2_ff.wp) begin
                wpSeen_ff <= 1'b1;
            end
            if (riseEv) begin
                if (bitCnt_ff != ACK_SLOT) begin
                    if (state_ff != ST_RDATA) begin
                        shift_ff <= {shift_ff[6:0], riseBit_ff};
                    end
                    bitCnt_ff <= bitCnt_ff + 4'h1;
                end else begin
                    bitCnt_ff <= 4'h0;
                    ackDone_ff <= 1'b1;
                    if (state_ff == ST_RDATA) begin
                        if (riseBit_ff) begin
                            state_ff <= ST_IDLE;
                        end else begin
                            shift_ff <= mem[addr_ff];
                        end
                    end
                end
            end else if (byteDone) begin
                case (state_ff)
                    ST_SEL: begin
                        if (selMatch) begin
                            sdaOe_ff <= 1'b1;
                            addr_ff <= withHi(addr_ff, shift_ff[CE_MSB:CE_LSB]);
                            if (shift_ff[RW_POS]) begin
                                state_ff <= ST_RDATA;
                                shift_ff <= mem[withHi(addr_ff, shift_ff[CE_MSB:CE_LSB])];
                            end else begin
                                state_ff <= ST_ADDR;
                            end
                        end else begin
                            sdaOe_ff <= 1'b0;
                            state_ff <= ST_IDLE;
                        end
                    end
                    ST_ADDR: begin
                        sdaOe_ff <= 1'b1;
                        addr_ff <= withLow(addr_ff, shift_ff);
                        state_ff <= ST_WDATA;
                        if (pins2_ff.wp) begin
                            wpSeen_ff <= 1'b1;
                        end
                    end
                    ST_WDATA: begin
                        sdaOe_ff <= ~wpSeen_ff;
                        if (!wpSeen_ff) begin
                            dataSeen_ff <= 1'b1;
                            addr_ff[PAGE_BITS-1:0] <= addr_ff[PAGE_BITS-1:0] + 4'h1;
                        end
                    end
                    ST_RDATA: begin
                        sdaOe_ff <= 1'b0;
                        addr_ff <= addr_ff + 1'b1;
                    end
                    default: begin
                        sdaOe_ff <= 1'b0;
                    end
                endcase
            end else if (fallEv) begin
                if (state_ff == ST_RDATA && (ackDone_ff || bitCnt_ff != 4'h0)) begin
                    sdaOe_ff <= ~shift_ff[7];
                    shift_ff <= {shift_ff[6:0], 1'b0};
                    ackDone_ff <= 1'b0;
                end else if (ackDone_ff) begin
                    sdaOe_ff <= 1'b0;
                    ackDone_ff <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // Write cycle timer
    // ****************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            busyCnt_ff <= '0;
        end else if (state_ff != ST_BUSY && stopEv && writeGo) begin
            busyCnt_ff <= CNT_W'(WRITE_CYCLES - 1);
        end else if (state_ff == ST_BUSY && busyCnt_ff != '0) begin
            busyCnt_ff <= busyCnt_ff - 1'b1;
        end
    end

    // ****************************************
    // Page latches and array
    // ****************************************
    // Latches hold a whole page so roll-over simply overwrites a slot
    always_ff @(posedge clk) begin
        if (reset) begin
            pageValid_ff <= '0;
        end else if (commit) begin
            pageValid_ff <= '0;
        end else if (pageStore) begin
            pageValid_ff[addr_ff[PAGE_BITS-1:0]] <= 1'b1;
        end else if (startEv && state_ff != ST_BUSY) begin
            pageValid_ff <= '0;
        end
    end

    always_ff @(posedge clk) begin
        if (pageStore) begin
            pageData_ff[addr_ff[PAGE_BITS-1:0]] <= shift_ff;
        end
    end

    // Array contents are not reset; they model nonvolatile cells
    always_ff @(posedge clk) begin
        if (commit) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (pageValid_ff[i]) begin
                    mem[{addr_ff[AW-1:PAGE_BITS], PAGE_BITS'(i)}] <= pageData_ff[i];
                end
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign sdaOut = 1'b0;
    assign sdaOe = sdaOe_ff;
    assign writeBusy = state_ff == ST_BUSY;

endmodule // isee_slave

// file: test/isee_host.sv
// Bus master model that drives the serial clock and data
`timescale 1ns/1ps

module isee_host (
    input wire logic clk,
    input wire logic sdaWire,
    output logic scl,
    output logic pullLow
);
    // SCL rests high outside frames; released SDA floats to the pull-up
    initial begin
        scl = 1'b1;
        pullLow = 1'b0;
    end

    // Edges sit 3 ns off the clk grid so nothing races the slave
    task automatic clock_pulses(input int n);
        #3;
        repeat (n) begin
            #24 scl = 1'b0;
            #24 scl = 1'b1;
        end
    endtask

    task automatic xbit(input logic b, output logic r);
        #12 pullLow = ~b;
        #12 scl = 1'b1;
        #12 r = sdaWire;
        #12 scl = 1'b0;
    endtask

    task automatic start_cond();
        @(posedge clk);
        #3 pullLow = 1'b0;
        #24 scl = 1'b1;
        #24 pullLow = 1'b1;
        #24 scl = 1'b0;
    endtask

    task automatic stop_cond();
        #12 pullLow = 1'b1;
        #12 scl = 1'b1;
        #24 pullLow = 1'b0;
        #24;
    endtask

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(d[i], r);
        end
        xbit(1'b1, r);
        ack = ~r;
    endtask

    task automatic recv_byte(input logic ackIt, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(1'b1, r);
            d[i] = r;
        end
        xbit(~ackIt, r);
    endtask
endmodule // isee_host

// file: test/isee_slave_asserts.sv
// Port assertions for the serial memory slave
`timescale 1ns/1ps

module isee_slave_asserts
    import isee_pkg::*;
#(
    parameter int WRITE_CYCLES = DEF_WRITE_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic sclClk,
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic [2:0] chipSelPin,
    input wire logic writeProtectIn,
    input wire logic writeBusy
);
    int busyRun_ff;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // Length of the current busy run, read when it ends
    always_ff @(posedge clk) begin
        busyRun_ff <= (reset || !writeBusy) ? 0 : busyRun_ff + 1;
    end

    a_drain_zero: assert property (sdaOut == 1'b0)
        else $error("data output not zero");
    a_pull_holds: assert property ($rose(sdaOe) |-> sdaOe [*4])
        else $error("pull shorter than a bit");
    a_release_holds: assert property ($fell(sdaOe) |-> !sdaOe [*4])
        else $error("release shorter than a bit");
    a_stable_high: assert property (sclIn && $past(sclIn) && $past(sclIn, 2) |-> $stable(sdaOe))
        else $error("data moved while clock high");
    a_busy_silent: assert property (writeBusy |-> !sdaOe)
        else $error("driving data while busy");
    a_busy_span: assert property ($fell(writeBusy) |->
        busyRun_ff >= WRITE_CYCLES - 1 && busyRun_ff <= WRITE_CYCLES + 1)
        else $error("busy length wrong");
    a_busy_on_stop: assert property ($rose(writeBusy) |-> sclIn && sdaIn && $past(sclIn, 3))
        else $error("busy without stop");
    a_reset_quiet: assert property ($fell(reset) |-> !sdaOe && !writeBusy)
        else $error("outputs active after reset");
endmodule // isee_slave_asserts

bind isee_slave isee_slave_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) u_isee_slave_asserts (
    .clk(clk), .reset(reset), .sclClk(sclClk), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .chipSelPin(chipSelPin), .writeProtectIn(writeProtectIn), .writeBusy(writeBusy));

// file: test/isee_slave_tb.sv
// Self-checking bench for the serial memory slave
`timescale 1ns/1ps

`define CHK(nm, exp, got) \
    begin \
        totalChecks++; \
        if ((got) !== (exp)) begin \
            fails++; \
            $display("BAD %s exp=%0h got=%0h", nm, exp, got); \
        end \
    end

module isee_slave_tb
    import isee_pkg::*;
;
    localparam int BUSY_CYCLES = 20;
    localparam int TOP = 4 * BITS_PER_KBIT_BYTES - 1;
    // Arbitrary type code, shared with the instance
    localparam logic [3:0] TYPE_ID = 4'h9;
    logic clk;
    logic reset;
    logic [2:0] chipSelPin;
    logic writeProtectIn;
    logic scl;
    logic pullLow;
    logic sdaOe;
    logic sdaOut;
    logic writeBusy;
    wire logic sda;
    logic [7:0] mem [int];
    int cnt;
    int fails = 0;
    int totalChecks = 0;
    int cycles = 0;
    int seed = 32260;

    assign sda = ~(pullLow | (sdaOe & ~sdaOut));

    isee_slave #(.KBITS(4), .WRITE_CYCLES(BUSY_CYCLES), .DEVICE_TYPE_ID(TYPE_ID)) u_isee_slave (
        .clk(clk), .reset(reset), .sclClk(scl), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .chipSelPin(chipSelPin), .writeProtectIn(writeProtectIn), .writeBusy(writeBusy));
    isee_host u_isee_host (.clk(clk), .sdaWire(sda), .scl(scl), .pullLow(pullLow));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    function automatic logic [7:0] sel(input int a, input logic rd);
        return {TYPE_ID, chipSelPin[2:1], a[8], rd};
    endfunction

    task automatic page_write(input int a, input int n);
        logic ack;
        logic [7:0] d;
        logic prot;
        prot = writeProtectIn;
        u_isee_host.start_cond();
        u_isee_host.send_byte(sel(a, 1'b0), ack);
        `CHK("sel ack", 1'b1, ack)
        u_isee_host.send_byte(a[7:0], ack);
        `CHK("addr ack", 1'b1, ack)
        // Dropping protect after the address must not unlock the data
        fork
            @(negedge clk) writeProtectIn = 1'b0;
        join_none
        for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            u_isee_host.send_byte(d, ack);
            `CHK("data ack", ~prot, ack)
            if (!prot) begin
                mem[(a & ~15) | ((a + i) & 15)] = d;
            end
        end
        u_isee_host.stop_cond();
        if (!prot) begin
            u_isee_host.start_cond();
            `CHK("busy", 1'b1, writeBusy)
            u_isee_host.send_byte(sel(a, 1'b0), ack);
            `CHK("poll busy", 1'b0, ack)
            u_isee_host.stop_cond();
            `CHK("busy end", 1'b0, writeBusy)
            u_isee_host.start_cond();
            u_isee_host.send_byte(sel(a, 1'b0), ack);
            `CHK("poll ready", 1'b1, ack)
            u_isee_host.stop_cond();
        end
        repeat (6) @(negedge clk);
        `CHK("no busy", 1'b0, writeBusy)
    endtask

    task automatic torn_write(input int a);
        logic ack;
        logic r;
        u_isee_host.start_cond();
        u_isee_host.send_byte(sel(a, 1'b0), ack);
        u_isee_host.send_byte(a[7:0], ack);
        u_isee_host.send_byte(8'h3c, ack);
        `CHK("torn ack", 1'b1, ack)
        u_isee_host.xbit(1'b0, r);
        u_isee_host.stop_cond();
        repeat (6) @(negedge clk);
        `CHK("torn busy", 1'b0, writeBusy)
    endtask

    task automatic seq_read(input int a, input logic fresh, input int n);
        logic ack;
        logic [7:0] d;
        if (fresh) begin
            u_isee_host.start_cond();
            u_isee_host.send_byte(sel(a, 1'b0), ack);
            u_isee_host.send_byte(a[7:0], ack);
            cnt = a;
        end
        u_isee_host.start_cond();
        u_isee_host.send_byte(sel(cnt, 1'b1), ack);
        `CHK("read sel", 1'b1, ack)
        for (int i = 0; i < n; i++) begin
            u_isee_host.recv_byte(i < n - 1, d);
            `CHK("read data", mem[cnt], d)
            cnt = (cnt + 1) % (TOP + 1);
        end
        u_isee_host.stop_cond();
    endtask

    task automatic reject(input logic [7:0] s);
        logic ack;
        u_isee_host.start_cond();
        u_isee_host.send_byte(s, ack);
        `CHK("bad sel", 1'b0, ack)
        u_isee_host.stop_cond();
    endtask

    initial begin
        reset = 1'b1;
        chipSelPin = 3'b110;
        writeProtectIn = 1'b0;
        // Link reset is resynced on SCL, so it needs SCL edges in reset and after release
        u_isee_host.clock_pulses(4);
        @(negedge clk) reset = 1'b0;
        // Two idle pulses with data high drain the link reset before the first frame
        u_isee_host.clock_pulses(2);
        repeat (4) @(negedge clk);
        page_write('h11f, 4);
        seq_read('h110, 1'b1, 3);
        torn_write('h11f);
        seq_read('h11f, 1'b1, 1);
        @(negedge clk) writeProtectIn = 1'b1;
        page_write('h110, 2);
        page_write(TOP, 1);
        page_write(0, 1);
        @(negedge clk) writeProtectIn = 1'b1;
        seq_read('h110, 1'b1, 1);
        seq_read(TOP, 1'b1, 2);
        seq_read(TOP, 1'b1, 1);
        seq_read(0, 1'b0, 1);
        for (int k = 0; k < 4; k++) begin
            reject({k == 3 ? ~TYPE_ID : TYPE_ID, k[1:0], 2'b01});
        end
        complete_run();
    end
endmodule // isee_slave_tb
